// [cpm_pin_mux.sv]
`timescale 1ns/1ps
// What this block does
// RULE1: reset puts every channel in uart function
// RULE2: uart outputs drive from start-up onward
// RULE3: outside logic avoids driving uart outputs early
// RULE4: mode selects each channel's pin functions
// RULE5: wake drives line0 low, line1 high, line3 low
// RULE6: supply enable high when suspended or unconfigured
// RULE7: suspend output low while link suspended
// RULE8: status outputs same in every mode
// RULE9: eeprom pins undriven while in reset
// RULE10: eeprom clock driven outside reset
// RULE11: reset input is active low
// RULE12: gpio defaults to input with pull-down
// RULE13: gpio 0..2 can be i2c and interrupt
// RULE14: uart ctrl line0 is ring or rs485 enable
// RULE15: mode change hits all pins together
// RULE16: unused pins stay undriven inputs
module cpm_pin_mux (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic reset_pin_n,
  input wire cpm_pkg::cpm_mode_e mode_a,
  input wire cpm_pkg::cpm_mode_e mode_b,
  input wire logic rs485_drive_enable_sel_a,
  input wire logic rs485_drive_enable_sel_b,
  input wire logic wake_a,
  input wire logic wake_b,
  input wire cpm_pkg::cpm_func_s func_a,
  input wire cpm_pkg::cpm_func_s func_b,
  input wire logic usb_suspended,
  input wire logic usb_configured,
  input wire logic ee_sel,
  input wire logic ee_clk,
  input wire logic ee_data_out,
  input wire logic ee_data_oe,
  input wire logic i2c_sel,
  input wire logic i2c_sda_oe,
  input wire logic i2c_scl_oe,
  input wire logic i2c_int_req,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_dir,
  output cpm_pkg::cpm_pins_s chan_a_pins,
  output cpm_pkg::cpm_pins_s chan_b_pins,
  output logic supply_enable_n,
  output logic suspend_n,
  output logic eeprom_select,
  output logic eeprom_select_oe,
  output logic eeprom_clock_out,
  output logic eeprom_clock_oe,
  output logic eeprom_data_o,
  output logic eeprom_data_oe,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe,
  output logic [7:0] gpio_pull_down
);
  logic rst_meta_reg;   // reset pin first stage
  logic rst_sync_reg;   // reset pin second stage
  logic in_reset;       // combined reset condition
  logic susp_meta_reg;  // suspend first stage
  logic susp_sync_reg;  // suspend second stage
  logic chan_rst;       // reset into the channel maps

  //////////////////////////////////////////////////////////////////////////
  // reset pin synchroniser, low pin means reset
  always_ff @(posedge clk) begin
    if (srst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= reset_pin_n;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // active-low pin folded into internal reset, see RULE11
  assign in_reset = srst | ~rst_sync_reg;
  assign chan_rst = in_reset;

  //////////////////////////////////////////////////////////////////////////
  // suspend state synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      susp_meta_reg <= 1'b0;
      susp_sync_reg <= 1'b0;
    end else if (ce) begin
      susp_meta_reg <= usb_suspended;
      susp_sync_reg <= susp_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // channel maps, outside logic keeps off uart outputs (see RULE3)
  cpm_chan_map u_map_a (
    .clk(clk),
    .srst(chan_rst),
    .ce(ce),
    .mode(mode_a),
    .rs485_drive_enable_sel(rs485_drive_enable_sel_a),
    .wake(wake_a),
    .func(func_a),
    .pins(chan_a_pins)
  );

  cpm_chan_map u_map_b (
    .clk(clk),
    .srst(chan_rst),
    .ce(ce),
    .mode(mode_b),
    .rs485_drive_enable_sel(rs485_drive_enable_sel_b),
    .wake(wake_b),
    .func(func_b),
    .pins(chan_b_pins)
  );

  //////////////////////////////////////////////////////////////////////////
  // status outputs, independent of either mode (see RULE8)
  always_ff @(posedge clk) begin
    if (in_reset) begin
      supply_enable_n <= 1'b1;
      suspend_n <= 1'b1;
    end else if (ce) begin
      // high when suspended or not configured, see RULE6
      supply_enable_n <= susp_sync_reg | ~usb_configured;
      // low only while suspended, see RULE7
      suspend_n <= ~susp_sync_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // eeprom pins: released in reset; select and clock driven after, data per ee_data_oe
  always_ff @(posedge clk) begin
    if (in_reset) begin
      // all three undriven, see RULE9
      eeprom_select <= 1'b0;
      eeprom_select_oe <= 1'b0;
      eeprom_clock_out <= 1'b0;
      eeprom_clock_oe <= 1'b0;
      eeprom_data_o <= 1'b0;
      eeprom_data_oe <= 1'b0;
    end else if (ce) begin
      eeprom_select <= ee_sel;
      eeprom_select_oe <= 1'b1;
      // serial clock toward the eeprom, see RULE10
      eeprom_clock_out <= ee_clk;
      eeprom_clock_oe <= 1'b1;
      eeprom_data_o <= ee_data_out;
      eeprom_data_oe <= ee_data_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // general-purpose pins, one slice per pin
  genvar gi;
  generate
    for (gi = 0; gi < cpm_pkg::CPM_GPIO; gi++) begin : g_gpio
      logic alt; // pin taken by the i2c function
      assign alt = i2c_sel && cpm_pkg::CPM_I2C_MASK[gi];
      always_ff @(posedge clk) begin
        if (in_reset) begin
          // input with weak pull-down, see RULE12
          gpio_o[gi] <= 1'b0;
          gpio_oe[gi] <= 1'b0;
          gpio_pull_down[gi] <= 1'b1;
        end else if (ce) begin
          if (alt) begin
            // i2c lines open drain, interrupt active low, see RULE13
            gpio_o[gi] <= 1'b0;
            gpio_pull_down[gi] <= 1'b0;
            if (gi == cpm_pkg::CPM_GPIO_INT) begin
              gpio_oe[gi] <= i2c_int_req;
            end else if (gi == cpm_pkg::CPM_GPIO_SDA) begin
              gpio_oe[gi] <= i2c_sda_oe;
            end else begin
              gpio_oe[gi] <= i2c_scl_oe;
            end
          end else begin
            // plain gpio; pull-down kept while an input
            gpio_o[gi] <= gpio_out[gi];
            gpio_oe[gi] <= gpio_dir[gi];
            gpio_pull_down[gi] <= ~gpio_dir[gi];
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_uart_after_reset;
    @(posedge clk) $fell(in_reset) |->
      chan_a_pins.data_oe == cpm_pkg::CPM_UART_DATA_OE
      && chan_b_pins.ctrl_oe == cpm_pkg::CPM_UART_CTRL_OE;
  endproperty
  a_uart_after_reset: assert property (p_uart_after_reset) // see RULE1
    else $error("channel not in uart image after reset");

  property p_uart_drive;
    @(posedge clk) disable iff (in_reset)
      ce && mode_a == cpm_pkg::CPM_MODE_UART && !wake_a
      |=> chan_a_pins.data_oe[cpm_pkg::CPM_U_TXD];
  endproperty
  a_uart_drive: assert property (p_uart_drive) // see RULE2
    else $error("uart transmit line not driven");

  property p_mode_map;
    @(posedge clk) disable iff (in_reset)
      ce && mode_b == cpm_pkg::CPM_MODE_HOSTBUS
      |=> chan_b_pins.ctrl_oe == cpm_pkg::CPM_HB_CTRL_OE;
  endproperty
  a_mode_map: assert property (p_mode_map) // see RULE4
    else $error("host bus address lines not driven");

  property p_wake;
    @(posedge clk) disable iff (in_reset)
      ce && wake_a |=> (chan_a_pins.ctrl_oe & cpm_pkg::CPM_WAKE_OE)
      == cpm_pkg::CPM_WAKE_OE
      && (chan_a_pins.ctrl_o & cpm_pkg::CPM_WAKE_OE)
      == cpm_pkg::CPM_WAKE_VAL;
  endproperty
  a_wake: assert property (p_wake) // see RULE5
    else $error("wake pattern wrong");

  property p_supply;
    @(posedge clk) disable iff (in_reset)
      ce && !usb_configured |=> supply_enable_n;
  endproperty
  a_supply: assert property (p_supply) // see RULE6
    else $error("supply enable low while unconfigured");

  property p_suspend;
    @(posedge clk) disable iff (in_reset)
      ce |=> suspend_n == !$past(susp_sync_reg);
  endproperty
  a_suspend: assert property (p_suspend) // see RULE7
    else $error("suspend output disagrees with link state");

  property p_ee_reset;
    @(posedge clk) in_reset |=>
      !eeprom_select_oe && !eeprom_clock_oe && !eeprom_data_oe;
  endproperty
  a_ee_reset: assert property (p_ee_reset) // see RULE9
    else $error("eeprom pin driven in reset");

  property p_ee_clk;
    @(posedge clk) disable iff (in_reset)
      ce |=> eeprom_clock_oe && eeprom_clock_out == $past(ee_clk);
  endproperty
  a_ee_clk: assert property (p_ee_clk) // see RULE10
    else $error("eeprom clock not driven");

  property p_gpio_default;
    @(posedge clk) in_reset |=> gpio_oe == 8'h00 && gpio_pull_down == 8'hff;
  endproperty
  a_gpio_default: assert property (p_gpio_default) // see RULE12
    else $error("gpio default wrong");

  property p_unused;
    @(posedge clk) disable iff (in_reset)
      ce && mode_a == cpm_pkg::CPM_MODE_RSVD && !wake_a
      |=> chan_a_pins.data_oe == 8'h00 && chan_a_pins.ctrl_oe == 8'h00;
  endproperty
  a_unused: assert property (p_unused) // see RULE16
    else $error("pin driven with no function");

  c_wake: cover property (@(posedge clk) ce && wake_b);
  c_mode_sw: cover property (@(posedge clk) ce && $changed(mode_a));
  c_suspend: cover property (@(posedge clk) $fell(suspend_n));
  c_i2c: cover property (@(posedge clk) ce && i2c_sel && i2c_int_req);
endmodule

// [cpm_pkg.sv]
package cpm_pkg;
  // interface mode codes, one per channel
  typedef enum logic [2:0] {
    CPM_MODE_UART     = 3'h0,
    CPM_MODE_FIFO     = 3'h1,
    CPM_MODE_BITBANG  = 3'h2,
    CPM_MODE_SSE      = 3'h3,
    CPM_MODE_FAST     = 3'h4,
    CPM_MODE_CPUFIFO  = 3'h5,
    CPM_MODE_HOSTBUS  = 3'h6,
    CPM_MODE_RSVD     = 3'h7
  } cpm_mode_e;

  // line counts
  localparam int CPM_LINES = 8;
  localparam int CPM_GPIO = 8;

  // per-channel function side signals
  typedef struct packed {
    logic [7:0] data_out;   // data-bus drive values
    logic [7:0] data_oe;    // data-bus direction, high drives
    logic [7:0] ctrl_out;   // control-bus drive values
    logic [7:0] ctrl_oe;    // control-bus direction request
  } cpm_func_s;

  // pin side of one channel
  typedef struct packed {
    logic [7:0] data_o;
    logic [7:0] data_oe;
    logic [7:0] ctrl_o;
    logic [7:0] ctrl_oe;
  } cpm_pins_s;

  // uart line positions
  localparam int CPM_U_TXD = 0;
  localparam int CPM_U_RTS = 2;
  localparam int CPM_U_DTR = 4;
  localparam int CPM_U_RI = 7;
  localparam int CPM_C_RI_RS485_DRIVE_ENABLE = 0;
  localparam int CPM_C_RECEIVE_ACTIVITY_LED_N = 3;
  localparam int CPM_C_TRANSMIT_ACTIVITY_LED_N = 4;
  localparam int CPM_C_WAKE1 = 1;

  // fifo control lines driven by device
  localparam logic [7:0] CPM_FIFO_CTRL_OE = 8'h23;
  // bit-bang strobes on lines 1 and 2
  localparam logic [7:0] CPM_BB_CTRL_OE = 8'h06;
  // cpu fifo: no device-driven control lines
  localparam logic [7:0] CPM_CPU_CTRL_OE = 8'h00;
  // host bus: address lines all driven
  localparam logic [7:0] CPM_HB_CTRL_OE = 8'hff;
  // uart outputs on data bus: txd, rts, dtr
  localparam logic [7:0] CPM_UART_DATA_OE = 8'h15;
  // uart outputs on control bus: led lines
  localparam logic [7:0] CPM_UART_CTRL_OE = 8'h18;
  // fast serial: clock line 1 and data-out line 2, per function direction
  localparam logic [7:0] CPM_FAST_DATA_OE = 8'h06;
  // wake pattern: line0 low, line1 high, line3 low
  localparam logic [7:0] CPM_WAKE_OE = 8'h0b;
  localparam logic [7:0] CPM_WAKE_VAL = 8'h02;
  localparam logic [7:0] CPM_ZERO8 = 8'h00;
  // i2c alternate uses gpio 0..2
  localparam logic [7:0] CPM_I2C_MASK = 8'h07;
  localparam int CPM_GPIO_INT = 2;
  localparam int CPM_GPIO_SDA = 0;
endpackage

// [cpm_chan_map.sv]
`timescale 1ns/1ps
// one channel: turns the mode into registered pin drive values
module cpm_chan_map (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire cpm_pkg::cpm_mode_e mode,
  input wire logic rs485_drive_enable_sel,
  input wire logic wake,
  input wire cpm_pkg::cpm_func_s func,
  output cpm_pkg::cpm_pins_s pins
);
  cpm_pkg::cpm_pins_s pins_next; // combinational pin image

  //////////////////////////////////////////////////////////////////////////
  // mode decode
  always_comb begin
    pins_next = '0;
    case (mode)
      // uart: fixed outputs drive from reset on, see RULE2
      cpm_pkg::CPM_MODE_UART: begin
        pins_next.data_o = func.data_out;
        pins_next.data_oe = cpm_pkg::CPM_UART_DATA_OE;
        pins_next.ctrl_o = func.ctrl_out;
        pins_next.ctrl_oe = cpm_pkg::CPM_UART_CTRL_OE;
        // line 0 is ri input or rs485 enable, see RULE14
        pins_next.ctrl_oe[cpm_pkg::CPM_C_RI_RS485_DRIVE_ENABLE] = rs485_drive_enable_sel;
      end
      // fifo: data follows function direction, strobes driven, see RULE4
      cpm_pkg::CPM_MODE_FIFO: begin
        pins_next.data_o = func.data_out;
        pins_next.data_oe = func.data_oe;
        pins_next.ctrl_o = func.ctrl_out;
        pins_next.ctrl_oe = cpm_pkg::CPM_FIFO_CTRL_OE;
      end
      // bit-bang: data per software direction, see RULE4
      cpm_pkg::CPM_MODE_BITBANG: begin
        pins_next.data_o = func.data_out;
        pins_next.data_oe = func.data_oe;
        pins_next.ctrl_o = func.ctrl_out;
        pins_next.ctrl_oe = cpm_pkg::CPM_BB_CTRL_OE;
      end
      // serial engine: every line software directed, see RULE4
      cpm_pkg::CPM_MODE_SSE: begin
        pins_next.data_o = func.data_out;
        pins_next.data_oe = func.data_oe;
        pins_next.ctrl_o = func.ctrl_out;
        pins_next.ctrl_oe = func.ctrl_oe;
      end
      // fast serial: clock and data out lines, see RULE4
      cpm_pkg::CPM_MODE_FAST: begin
        pins_next.data_o = func.data_out;
        pins_next.data_oe = cpm_pkg::CPM_FAST_DATA_OE & func.data_oe;
      end
      // cpu fifo: data bus only when read, see RULE4
      cpm_pkg::CPM_MODE_CPUFIFO: begin
        pins_next.data_o = func.data_out;
        pins_next.data_oe = func.data_oe;
        pins_next.ctrl_oe = cpm_pkg::CPM_CPU_CTRL_OE;
      end
      // host bus: address/data and high address lines, see RULE4
      cpm_pkg::CPM_MODE_HOSTBUS: begin
        pins_next.data_o = func.data_out;
        pins_next.data_oe = func.data_oe;
        pins_next.ctrl_o = func.ctrl_out;
        pins_next.ctrl_oe = cpm_pkg::CPM_HB_CTRL_OE;
      end
      // unused code: everything left as input, see RULE16
      default: begin
        pins_next = '0;
      end
    endcase
    // wake-up pattern overrides lines 0, 1 and 3, see RULE5
    if (wake) begin
      pins_next.ctrl_oe = pins_next.ctrl_oe | cpm_pkg::CPM_WAKE_OE;
      pins_next.ctrl_o = (pins_next.ctrl_o & ~cpm_pkg::CPM_WAKE_OE)
                         | cpm_pkg::CPM_WAKE_VAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one register for the whole channel, all pins switch together
  always_ff @(posedge clk) begin
    if (srst) begin
      // uart image with idle-high outputs, see RULE1
      pins.data_o <= cpm_pkg::CPM_UART_DATA_OE;
      pins.data_oe <= cpm_pkg::CPM_UART_DATA_OE;
      pins.ctrl_o <= cpm_pkg::CPM_UART_CTRL_OE;
      pins.ctrl_oe <= cpm_pkg::CPM_UART_CTRL_OE;
    end else if (ce) begin
      pins <= pins_next; // see RULE15
    end
  end
endmodule

// [cpm_ext_logic.sv]
`timescale 1ns/1ps
// far-side logic on one channel's data lines: resolves the wire level
// and drives its own lines only once the application allows it
module cpm_ext_logic (
  input wire logic clk,
  input wire logic srst,
  input wire cpm_pkg::cpm_pins_s pins,
  input wire logic ext_ok,
  input wire logic [7:0] ext_drive,
  output logic [7:0] data_level,
  output logic [7:0] clash_count
);
  logic [7:0] ext_oe; // lines driven from outside
  logic [7:0] float_pat; // level of a line nobody drives
  //////////////////////////////////////////////////////////////////
  // outside drive held off until mode and directions are set
  assign ext_oe = ext_ok ? ext_drive : 8'h00;
  // resolved wire level; undriven lines wander every cycle
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pins.data_oe[i]) begin
        data_level[i] = pins.data_o[i];
      end else begin
        data_level[i] = float_pat[i];
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // floating pattern and contention counter
  always_ff @(posedge clk) begin
    if (srst) begin
      float_pat <= 8'h55;
      clash_count <= 8'h00;
    end else begin
      float_pat <= ~float_pat;
      if ((ext_oe & pins.data_oe) != 8'h00) begin
        clash_count <= clash_count + 8'h01;
      end
    end
  end
endmodule

// [tb_cpm_pin_mux.sv]
`timescale 1ns/1ps
// self-checking bench for the pin-function multiplexer
module tb_cpm_pin_mux;
  logic clk, srst, ce, reset_pin_n;
  cpm_pkg::cpm_mode_e mode_a, mode_b;
  logic rs485_drive_enable_sel_a, rs485_drive_enable_sel_b, wake_a, wake_b;
  cpm_pkg::cpm_func_s func_a, func_b;
  logic usb_suspended, usb_configured;
  logic ee_sel, ee_clk, ee_data_out, ee_data_oe;
  logic i2c_sel, i2c_sda_oe, i2c_scl_oe, i2c_int_req;
  logic [7:0] gpio_out, gpio_dir;
  cpm_pkg::cpm_pins_s chan_a_pins, chan_b_pins;
  logic supply_enable_n, suspend_n;
  logic eeprom_select, eeprom_select_oe, eeprom_clock_out, eeprom_clock_oe;
  logic eeprom_data_o, eeprom_data_oe;
  logic [7:0] gpio_o, gpio_oe, gpio_pull_down;
  logic ext_ok; // outside logic may drive its own lines (uart inputs)
  logic [7:0] lvl_a, clash_a;
  int mismatches, n_checks;
  logic [7:0] exp_d [8]; // data direction per mode, func oe all high
  logic [7:0] exp_c [8]; // control direction per mode
  //////////////////////////////////////////////////////////////////
  cpm_pin_mux uut (.clk(clk), .srst(srst), .ce(ce),
    .reset_pin_n(reset_pin_n), .mode_a(mode_a), .mode_b(mode_b),
    .rs485_drive_enable_sel_a(rs485_drive_enable_sel_a), .rs485_drive_enable_sel_b(rs485_drive_enable_sel_b),
    .wake_a(wake_a), .wake_b(wake_b), .func_a(func_a), .func_b(func_b),
    .usb_suspended(usb_suspended), .usb_configured(usb_configured),
    .ee_sel(ee_sel), .ee_clk(ee_clk), .ee_data_out(ee_data_out),
    .ee_data_oe(ee_data_oe), .i2c_sel(i2c_sel), .i2c_sda_oe(i2c_sda_oe),
    .i2c_scl_oe(i2c_scl_oe), .i2c_int_req(i2c_int_req),
    .gpio_out(gpio_out), .gpio_dir(gpio_dir), .chan_a_pins(chan_a_pins),
    .chan_b_pins(chan_b_pins), .supply_enable_n(supply_enable_n),
    .suspend_n(suspend_n), .eeprom_select(eeprom_select),
    .eeprom_select_oe(eeprom_select_oe),
    .eeprom_clock_out(eeprom_clock_out), .eeprom_clock_oe(eeprom_clock_oe),
    .eeprom_data_o(eeprom_data_o), .eeprom_data_oe(eeprom_data_oe),
    .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_pull_down(gpio_pull_down));
  cpm_ext_logic far_a (.clk(clk), .srst(srst), .pins(chan_a_pins),
    .ext_ok(ext_ok), .ext_drive(8'h0a), .data_level(lvl_a),
    .clash_count(clash_a));
  //////////////////////////////////////////////////////////////////
  // clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // let one input change reach the registered outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one step of stimulus on both channels
  task automatic set_mode(input cpm_pkg::cpm_mode_e m);
    @(posedge clk);
    mode_a <= m;
    mode_b <= m;
  endtask
  // verdict
  task automatic close_out;
    $display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    exp_d = '{8'h15, 8'hff, 8'hff, 8'hff, 8'h06, 8'hff, 8'hff, 8'h00};
    exp_c = '{8'h18, 8'h23, 8'h06, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
    mismatches = 0; n_checks = 0;
    srst = 1'b1; ce = 1'b1; reset_pin_n = 1'b1; ext_ok = 1'b0;
    mode_a = cpm_pkg::CPM_MODE_SSE; mode_b = cpm_pkg::CPM_MODE_FIFO;
    rs485_drive_enable_sel_a = 1'b0; rs485_drive_enable_sel_b = 1'b0; wake_a = 1'b0; wake_b = 1'b0;
    func_a = 32'hffffffff; func_b = 32'hffffffff;
    usb_suspended = 1'b0; usb_configured = 1'b0;
    ee_sel = 1'b1; ee_clk = 1'b1; ee_data_out = 1'b1; ee_data_oe = 1'b1;
    i2c_sel = 1'b0; i2c_sda_oe = 1'b0; i2c_scl_oe = 1'b0;
    i2c_int_req = 1'b0; gpio_out = 8'h00; gpio_dir = 8'h00;
    settle(16);
    chk({chan_a_pins.data_oe, chan_a_pins.ctrl_oe}, 32'h1518);
    chk({chan_b_pins.data_oe, chan_b_pins.ctrl_oe}, 32'h1518);
    chk({eeprom_select_oe, eeprom_clock_oe, eeprom_data_oe}, 0);
    chk({gpio_oe, gpio_pull_down}, 32'h00ff);
    @(posedge clk);
    srst <= 1'b0;
    ext_ok <= 1'b1;
    mode_a <= cpm_pkg::CPM_MODE_UART;
    mode_b <= cpm_pkg::CPM_MODE_UART;
    settle(3);
    // uart outputs drive as soon as the block runs
    chk(chan_a_pins.data_oe, 8'h15);
    chk(lvl_a & 8'h15, 8'h15);
    chk({eeprom_select, eeprom_select_oe, eeprom_data_o, eeprom_data_oe},
        4'hf);
    chk(supply_enable_n, 1'b1);
    chk(eeprom_clock_oe, 1'b1);
    chk(eeprom_clock_out, ee_clk);
    @(posedge clk);
    ee_clk <= 1'b0;
    settle(2);
    chk(eeprom_clock_out, 1'b0);
    // rs485 enable on control line 0, then back to ring input
    @(posedge clk);
    rs485_drive_enable_sel_a <= 1'b1;
    rs485_drive_enable_sel_b <= 1'b1;
    settle(2);
    chk(chan_a_pins.ctrl_oe, 8'h19);
    chk(chan_b_pins.ctrl_oe, 8'h19);
    @(posedge clk);
    rs485_drive_enable_sel_a <= 1'b0;
    rs485_drive_enable_sel_b <= 1'b0;
    usb_configured <= 1'b1;
    settle(2);
    chk(chan_a_pins.ctrl_oe, 8'h18);
    // every mode code, status outputs checked in each one
    // outside logic keeps off while the device takes every line
    ext_ok <= 1'b0;
    for (int m = 7; m >= 0; m--) begin
      set_mode(cpm_pkg::cpm_mode_e'(m[2:0]));
      settle(2);
      chk(chan_a_pins.data_oe, exp_d[m]);
      chk(chan_b_pins.data_oe, exp_d[m]);
      chk(chan_a_pins.ctrl_oe, exp_c[m]);
      chk({supply_enable_n, suspend_n}, 2'b01);
    end
    // engine image passes through whole in one edge
    @(posedge clk);
    func_a <= 32'h3ca55ac3;
    mode_a <= cpm_pkg::CPM_MODE_SSE;
    settle(2);
    chk(chan_a_pins, 32'h3ca55ac3);
    // clock enable low freezes the image
    @(posedge clk);
    ce <= 1'b0;
    mode_a <= cpm_pkg::CPM_MODE_RSVD;
    settle(3);
    chk(chan_a_pins, 32'h3ca55ac3);
    @(posedge clk);
    ce <= 1'b1;
    settle(2);
    chk(chan_a_pins.data_oe, 8'h00);
    // wake pattern overrides the mode on both channels
    @(posedge clk);
    wake_a <= 1'b1;
    wake_b <= 1'b1;
    settle(2);
    chk({chan_a_pins.ctrl_oe & 8'h0b, chan_a_pins.ctrl_o & 8'h0b},
        16'h0b02);
    chk({chan_b_pins.ctrl_oe & 8'h0b, chan_b_pins.ctrl_o & 8'h0b},
        16'h0b02);
    @(posedge clk);
    wake_a <= 1'b0;
    wake_b <= 1'b0;
    usb_suspended <= 1'b1;
    settle(5);
    chk({supply_enable_n, suspend_n}, 2'b10);
    @(posedge clk);
    usb_suspended <= 1'b0;
    settle(5);
    chk({supply_enable_n, suspend_n}, 2'b01);
    // gpio drive and the i2c alternate on lines 0..2
    @(posedge clk);
    gpio_dir <= 8'h30;
    gpio_out <= 8'h10;
    i2c_sel <= 1'b1;
    i2c_sda_oe <= 1'b1;
    i2c_int_req <= 1'b1;
    settle(2);
    chk(gpio_oe, 8'h35);
    chk(gpio_o & 8'h37, 8'h10);
    chk(gpio_pull_down, 8'hc8);
    // pin reset, three edges to reach the pins
    @(posedge clk);
    reset_pin_n <= 1'b0;
    ext_ok <= 1'b1;
    settle(4);
    chk(chan_a_pins.data_oe, 8'h15);
    chk({eeprom_select_oe, eeprom_clock_oe, eeprom_data_oe}, 0);
    chk(gpio_pull_down, 8'hff);
    @(posedge clk);
    reset_pin_n <= 1'b1;
    settle(4);
    chk(eeprom_clock_oe, 1'b1);
    chk(clash_a, 8'h00);
    close_out();
  end
endmodule
